// file: pkg/gpg_pkg.sv
// gpg_pkg: register map, field layout and sense encodings of the pin group.
// assumes a 32-bit APB slave, one register per aligned word (index * 4).
package gpg_pkg;
  localparam int GPG_ADDR_W = 8;
  localparam int GPG_DATA_W = 32;
  localparam int GPG_IDX_W = 5;
  localparam int GPG_IDX_LSB = 2;
  typedef logic [GPG_IDX_W-1:0] gpg_idx_t;

  // register indices, byte address is index * 4
  localparam gpg_idx_t GPG_DRIVE = 5'h00;
  localparam gpg_idx_t GPG_DRIVE_SET = 5'h01;
  localparam gpg_idx_t GPG_DRIVE_CLEAR = 5'h02;
  localparam gpg_idx_t GPG_DRIVE_TOGGLE = 5'h03;
  localparam gpg_idx_t GPG_OUTPUT = 5'h04;
  localparam gpg_idx_t GPG_OUTPUT_SET = 5'h05;
  localparam gpg_idx_t GPG_OUTPUT_CLEAR = 5'h06;
  localparam gpg_idx_t GPG_OUTPUT_TOGGLE = 5'h07;
  localparam gpg_idx_t GPG_INPUT = 5'h08;
  localparam gpg_idx_t GPG_INT_FLAGS = 5'h09;
  localparam gpg_idx_t GPG_GROUP_CONTROL = 5'h0a;
  localparam gpg_idx_t GPG_SHARED_TEMPLATE = 5'h0b;
  localparam gpg_idx_t GPG_MULTI_UPDATE = 5'h0c;
  localparam gpg_idx_t GPG_MULTI_SET = 5'h0d;
  localparam gpg_idx_t GPG_MULTI_CLEAR = 5'h0e;
  localparam gpg_idx_t GPG_PIN_CONTROL_0 = 5'h10;
  localparam gpg_idx_t GPG_PIN_CONTROL_7 = 5'h17;
  // fast alias window
  localparam gpg_idx_t GPG_ALIAS_DRIVE = 5'h18;
  localparam gpg_idx_t GPG_ALIAS_OUTPUT = 5'h19;
  localparam gpg_idx_t GPG_ALIAS_INPUT = 5'h1a;
  localparam gpg_idx_t GPG_ALIAS_FLAGS = 5'h1b;

  // pin control fields
  localparam int GPG_FLIP_BIT = 7;
  localparam int GPG_THRESH_BIT = 6;
  localparam int GPG_PULL_BIT = 3;
  localparam int GPG_SENSE_MSB = 2;
  localparam int GPG_SENSE_LSB = 0;
  localparam int GPG_SLEW_BIT = 0;
  localparam logic [7:0] GPG_PIN_CTRL_RST = 8'h00;
  localparam logic [7:0] GPG_BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    GPG_SENSE_OFF = 3'b000,
    GPG_SENSE_BOTH = 3'b001,
    GPG_SENSE_RISE = 3'b010,
    GPG_SENSE_FALL = 3'b011,
    GPG_SENSE_IN_OFF = 3'b100,
    GPG_SENSE_LOW = 3'b101
  } gpg_sense_e;
endpackage : gpg_pkg

// file: pkg/gpg_pin_if.sv
// gpg_pin_if: per-pin bundle between the register file and one pin slice.
// assumes one instance per pin, driven from the group top.
`timescale 1ns/1ns
interface gpg_pin_if;
  logic [7:0] ctrl;
  logic drive;
  logic outv;
  logic ovr_drive_en;
  logic ovr_drive_val;
  logic ovr_out_en;
  logic ovr_out_val;
  logic in_val;
  logic sense_hit;
  logic sense_on;
  logic buf_en;
  logic pad_out;
  logic pad_oe;
  logic pad_pull;
  logic pad_ttl;
  logic evt;
  modport regs (output ctrl, drive, outv, ovr_drive_en, ovr_drive_val,
    ovr_out_en, ovr_out_val, input in_val, sense_hit, sense_on, buf_en,
    pad_out, pad_oe, pad_pull, pad_ttl, evt);
  modport pin (input ctrl, drive, outv, ovr_drive_en, ovr_drive_val,
    ovr_out_en, ovr_out_val, output in_val, sense_hit, sense_on, buf_en,
    pad_out, pad_oe, pad_pull, pad_ttl, evt);
endinterface : gpg_pin_if

// file: src/gpg_pin.sv
// gpg_pin: one pin slice: input synchroniser, inversion, sense, pad drive.
// assumes pad_in synchronous to pclk per bench convention.
`timescale 1ns/1ns
module gpg_pin (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic pad_in, // level seen on the pad
  gpg_pin_if.pin pif // control and status bundle
);
  import gpg_pkg::*;
  logic flip;
  logic [2:0] sense;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic level;
  logic rise;
  logic fall;
  logic hit;
  logic [2:0] sense_raw;

  assign flip = pif.ctrl[GPG_FLIP_BIT];
  assign sense_raw = pif.ctrl[GPG_SENSE_MSB:GPG_SENSE_LSB];
  assign sense = sense_raw;
  assign pif.buf_en = (sense != GPG_SENSE_IN_OFF); // R13 R1

  // synchroniser frozen while the input buffer is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (pif.buf_en) begin // R13
      sync1_reg <= pad_in; // R22
      sync2_reg <= sync1_reg; // R22
    end
  end

  // inversion sits ahead of edge detection so a flip shows as an edge
  assign level = sync2_reg ^ flip; // R9 R10 R6

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

  always_comb begin
    case (sense)
      GPG_SENSE_BOTH: hit = rise | fall;
      GPG_SENSE_RISE: hit = rise;
      GPG_SENSE_FALL: hit = fall;
      GPG_SENSE_LOW: hit = ~level;
      default: hit = 1'b0;
    endcase
  end

  assign pif.sense_hit = hit; // R23 R11
  assign pif.sense_on = (sense != GPG_SENSE_OFF) &&
    (sense != GPG_SENSE_IN_OFF); // R14
  assign pif.in_val = level; // R6
  assign pif.pad_oe = pif.ovr_drive_en ? pif.ovr_drive_val
                                       : pif.drive; // R21 R1
  assign pif.pad_out = (pif.ovr_out_en ? pif.ovr_out_val : pif.outv)
    ^ flip; // R9 R21
  assign pif.pad_pull = pif.ctrl[GPG_PULL_BIT] & ~pif.pad_oe; // R12
  assign pif.pad_ttl = pif.ctrl[GPG_THRESH_BIT]; // R11
  assign pif.evt = pif.buf_en & pad_in; // R24
endmodule : gpg_pin

// file: src/gpg_top.sv
// gpg_top: eight-pin general purpose I/O group with APB register access.
// assumes APB master on pclk; pads and overrides synchronous to pclk.
//
// Summary of operation
// R1: after reset drivers are off and input buffers are on.
// R2: drive-set and drive-clear bits set or clear drive enables.
// R3: output-set forces output bits to 1, output-clear to 0.
// R4: ones written to output-toggle or input value invert output bits.
// R5: ones written to drive-toggle invert drive enable bits.
// R6: input value shows sampled pin level unless input is disabled.
// R7: edge-rate-limit bit limits slew on all pins of the group.
// R8: pin n control register sits at offset 0x10 plus n.
// R9: polarity-flip inverts input and output paths of the pin.
// R10: flipping polarity gives an edge seen by peripherals and sensing; event_out is taken from pad_in ahead of the flip.
// R11: threshold-select picks Schmitt or TTL for input and sensing.
// R12: pull-up connects when enabled, disconnects while pin drives.
// R13: input-disable stops buffer and synchroniser, input value holds.
// R14: the sense field in pin control enables the pin interrupt.
// R15: multi-pin update copies the template into selected pin controls.
// R16: multi-pin set ORs the template into selected pin controls.
// R17: multi-pin clear removes template ones from selected pin controls.
// R18: template is shared by all groups; update/set/clear are local.
// R19: fast alias gives drive, output, input and flags, same behaviour.
// R20: software avoids alias access right after a regular access.
// R21: peripherals may override drive and value; rest stays with registers.
// R22: pin levels are synchronised to the clock before being read.
// R23: sense condition sets flag; request holds while enabled until cleared.
// R24: event output follows pin level while buffer on, else zero.
// R25: template reads and writes like a normal byte register.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
module gpg_top #(
  parameter int PINS = 8
) (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [gpg_pkg::GPG_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [gpg_pkg::GPG_DATA_W-1:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [gpg_pkg::GPG_DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [PINS-1:0] pad_in, // pad levels
  output logic [PINS-1:0] pad_out, // pad output values
  output logic [PINS-1:0] pad_oe, // pad driver enables
  output logic [PINS-1:0] pad_pull_up, // weak pull-up enables
  output logic [PINS-1:0] pad_ttl_sel, // 1 selects TTL thresholds
  output logic [PINS-1:0] pad_buf_en, // digital input buffer enables
  output logic slew_limit, // slew limiting for the group
  input wire logic [PINS-1:0] ovr_drive_en, // peripheral owns direction
  input wire logic [PINS-1:0] ovr_drive_val, // peripheral direction
  input wire logic [PINS-1:0] ovr_out_en, // peripheral owns value
  input wire logic [PINS-1:0] ovr_out_val, // peripheral value
  input wire logic tmpl_ext_wr, // template written in another group
  input wire logic [7:0] tmpl_ext_data, // that template value
  output logic tmpl_wr, // template written here
  output logic [7:0] tmpl_wdata, // value written here
  output logic [PINS-1:0] event_out, // pin level events
  output logic irq // group interrupt request
);
  import gpg_pkg::*;

  logic [PINS-1:0] drive_reg;
  logic [PINS-1:0] out_reg;
  logic [PINS-1:0] flags_reg;
  logic slew_reg;
  logic [7:0] tmpl_reg;
  logic [7:0] pin_ctrl_reg [PINS];
  logic [GPG_DATA_W-1:0] prdata_reg;
  logic pslverr_reg;

  logic [PINS-1:0] in_val;
  logic [PINS-1:0] hit;
  logic [PINS-1:0] sense_on;
  gpg_idx_t idx;
  logic addr_ok;
  logic setup;
  logic wr_acc;
  logic [PINS-1:0] wbits;
  logic [7:0] wbyte;

  gpg_pin_if pif[PINS] ();

  // alias indices fold onto the regular registers
  function automatic gpg_idx_t fold_index(input gpg_idx_t i);
    if (i == GPG_ALIAS_DRIVE) begin
      return GPG_DRIVE; // R19
    end else if (i == GPG_ALIAS_OUTPUT) begin
      return GPG_OUTPUT; // R19
    end else if (i == GPG_ALIAS_INPUT) begin
      return GPG_INPUT; // R19
    end else if (i == GPG_ALIAS_FLAGS) begin
      return GPG_INT_FLAGS; // R19
    end else begin
      return i;
    end
  endfunction : fold_index

  function automatic logic index_mapped(input gpg_idx_t i);
    if (i <= GPG_MULTI_CLEAR) begin
      return 1'b1;
    end else if (i >= GPG_PIN_CONTROL_0 &&
                 i < GPG_PIN_CONTROL_0 + gpg_idx_t'(PINS)) begin
      return 1'b1; // R8
    end else begin
      return 1'b0;
    end
  endfunction : index_mapped

  function automatic logic is_reg(input gpg_idx_t i, input gpg_idx_t r);
    return i == r;
  endfunction : is_reg

  // address decode
  assign idx = fold_index(paddr[GPG_IDX_LSB +: GPG_IDX_W]);
  assign addr_ok = (paddr[GPG_IDX_LSB-1:0] == '0) &&
    (paddr[GPG_ADDR_W-1:GPG_IDX_LSB+GPG_IDX_W] == '0) &&
    index_mapped(idx);
  assign setup = psel & ~penable;
  // only the low byte lane carries data; a write without it is ignored
  assign wr_acc = psel & penable & pwrite & addr_ok & pstrb[0];
  assign wbyte = pwdata[7:0];
  assign wbits = pwdata[PINS-1:0];

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // drive enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_reg <= '0; // R1
    end else if (wr_acc) begin
      if (is_reg(idx, GPG_DRIVE)) begin
        drive_reg <= wbits; // R19
      end else if (is_reg(idx, GPG_DRIVE_SET)) begin
        drive_reg <= drive_reg | wbits; // R2
      end else if (is_reg(idx, GPG_DRIVE_CLEAR)) begin
        drive_reg <= drive_reg & ~wbits; // R2
      end else if (is_reg(idx, GPG_DRIVE_TOGGLE)) begin
        drive_reg <= drive_reg ^ wbits; // R5
      end
    end
  end

  // output values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= '0;
    end else if (wr_acc) begin
      if (is_reg(idx, GPG_OUTPUT)) begin
        out_reg <= wbits; // R19
      end else if (is_reg(idx, GPG_OUTPUT_SET)) begin
        out_reg <= out_reg | wbits; // R3
      end else if (is_reg(idx, GPG_OUTPUT_CLEAR)) begin
        out_reg <= out_reg & ~wbits; // R3
      end else if (is_reg(idx, GPG_OUTPUT_TOGGLE) ||
                   is_reg(idx, GPG_INPUT)) begin
        out_reg <= out_reg ^ wbits; // R4
      end
    end
  end

  // interrupt flags: a new hit wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else if (wr_acc && is_reg(idx, GPG_INT_FLAGS)) begin
      flags_reg <= (flags_reg & ~wbits) | hit; // R23 R19
    end else begin
      flags_reg <= flags_reg | hit; // R23
    end
  end

  assign irq = |(flags_reg & sense_on); // R23 R14

  // group control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_reg <= 1'b0;
    end else if (wr_acc && is_reg(idx, GPG_GROUP_CONTROL)) begin
      slew_reg <= wbyte[GPG_SLEW_BIT]; // R7
    end
  end

  assign slew_limit = slew_reg; // R7

  // shared template: local write wins over a mirrored one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmpl_reg <= GPG_BYTE_RST;
    end else if (wr_acc && is_reg(idx, GPG_SHARED_TEMPLATE)) begin
      tmpl_reg <= wbyte; // R25
    end else if (tmpl_ext_wr) begin
      tmpl_reg <= tmpl_ext_data; // R18
    end
  end

  assign tmpl_wr = wr_acc && is_reg(idx, GPG_SHARED_TEMPLATE); // R18
  assign tmpl_wdata = wbyte;

  // per-pin control registers and pin slices
  genvar n;
  generate
    for (n = 0; n < PINS; n++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_ctrl_reg[n] <= GPG_PIN_CTRL_RST; // R1
        end else if (wr_acc) begin
          if (is_reg(idx, GPG_PIN_CONTROL_0 + gpg_idx_t'(n))) begin
            pin_ctrl_reg[n] <= wbyte; // R8 R14
          end else if (is_reg(idx, GPG_MULTI_UPDATE) && wbits[n]) begin
            pin_ctrl_reg[n] <= tmpl_reg; // R15 R18
          end else if (is_reg(idx, GPG_MULTI_SET) && wbits[n]) begin
            pin_ctrl_reg[n] <= pin_ctrl_reg[n] | tmpl_reg; // R16
          end else if (is_reg(idx, GPG_MULTI_CLEAR) && wbits[n]) begin
            pin_ctrl_reg[n] <= pin_ctrl_reg[n] & ~tmpl_reg; // R17
          end
        end
      end

      assign pif[n].ctrl = pin_ctrl_reg[n];
      assign pif[n].drive = drive_reg[n];
      assign pif[n].outv = out_reg[n];
      assign pif[n].ovr_drive_en = ovr_drive_en[n]; // R21
      assign pif[n].ovr_drive_val = ovr_drive_val[n];
      assign pif[n].ovr_out_en = ovr_out_en[n]; // R21
      assign pif[n].ovr_out_val = ovr_out_val[n];
      assign in_val[n] = pif[n].in_val;
      assign hit[n] = pif[n].sense_hit;
      assign sense_on[n] = pif[n].sense_on;
      assign pad_out[n] = pif[n].pad_out;
      assign pad_oe[n] = pif[n].pad_oe;
      assign pad_pull_up[n] = pif[n].pad_pull;
      assign pad_ttl_sel[n] = pif[n].pad_ttl;
      assign pad_buf_en[n] = pif[n].buf_en;
      assign event_out[n] = pif[n].evt;

      gpg_pin u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .pad_in(pad_in[n]),
        .pif(pif[n])
      );
    end
  endgenerate

  // read data captured in the setup cycle, valid in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      pslverr_reg <= ~addr_ok;
      prdata_reg <= '0;
      if (addr_ok && !pwrite) begin
        if (is_reg(idx, GPG_DRIVE)) begin
          prdata_reg[PINS-1:0] <= drive_reg;
        end else if (is_reg(idx, GPG_OUTPUT)) begin
          prdata_reg[PINS-1:0] <= out_reg;
        end else if (is_reg(idx, GPG_INPUT)) begin
          prdata_reg[PINS-1:0] <= in_val; // R6
        end else if (is_reg(idx, GPG_INT_FLAGS)) begin
          prdata_reg[PINS-1:0] <= flags_reg;
        end else if (is_reg(idx, GPG_GROUP_CONTROL)) begin
          prdata_reg[GPG_SLEW_BIT] <= slew_reg;
        end else if (is_reg(idx, GPG_SHARED_TEMPLATE)) begin
          prdata_reg[7:0] <= tmpl_reg; // R25
        end else if (idx >= GPG_PIN_CONTROL_0) begin
          prdata_reg[7:0] <= pin_ctrl_reg[3'(idx - GPG_PIN_CONTROL_0)];
        end
      end
    end
  end
endmodule : gpg_top

// file: test/gpg_top_properties.sv
// gpg_top_properties: port-level checks for the pin group.
// assumes binding into gpg_top; single pclk domain.
`timescale 1ns/1ns
module gpg_checker #(
  parameter int PINS = 8
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [gpg_pkg::GPG_ADDR_W-1:0] paddr, // apb address
  input wire logic [gpg_pkg::GPG_DATA_W-1:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb strobes
  input wire logic pslverr, // apb error
  input wire logic [PINS-1:0] pad_in, // pad levels
  input wire logic [PINS-1:0] pad_oe, // driver enables
  input wire logic [PINS-1:0] pad_pull_up, // pull-up enables
  input wire logic [PINS-1:0] pad_buf_en, // input buffer enables
  input wire logic slew_limit, // slew limiting
  input wire logic [PINS-1:0] ovr_drive_en, // direction override
  input wire logic [PINS-1:0] event_out, // pin events
  input wire logic tmpl_wr, // template written here
  input wire logic [7:0] tmpl_wdata, // template value sent
  input wire logic irq // interrupt request
);
  import gpg_pkg::*;
  logic wr_go;
  logic [4:0] wr_idx;
  assign wr_go = psel && penable && pwrite && pstrb[0] && !paddr[7]
    && paddr[1:0] == 2'h0;
  assign wr_idx = paddr[6:2];
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_reset_quiet: assert property (disable iff (1'b0)
    !presetn |-> pad_oe == '0 && &pad_buf_en)
    else $error("driver on or buffer off during reset");
  a_pull_off_drive: assert property ((pad_pull_up & pad_oe) == '0)
    else $error("pull-up left on a driven pin");
  a_event_gate: assert property (event_out == (pad_in & pad_buf_en))
    else $error("event output not gated by buffer");
  a_set_drives: assert property (wr_go && wr_idx == GPG_DRIVE_SET
    ##1 ovr_drive_en == '0 |-> (pad_oe & $past(pwdata[PINS-1:0]))
    == $past(pwdata[PINS-1:0])) else $error("drive set missed");
  a_clear_drives: assert property (wr_go && wr_idx == GPG_DRIVE_CLEAR
    ##1 ovr_drive_en == '0 |-> (pad_oe & $past(pwdata[PINS-1:0])) == '0)
    else $error("drive clear missed");
  a_toggle_drive: assert property (wr_go && wr_idx == GPG_DRIVE_TOGGLE
    && ovr_drive_en == '0 ##1 ovr_drive_en == '0
    |-> pad_oe == ($past(pad_oe) ^ $past(pwdata[PINS-1:0])))
    else $error("drive toggle wrong");
  a_slew_write: assert property (wr_go && wr_idx == GPG_GROUP_CONTROL
    |=> slew_limit == $past(pwdata[0])) else $error("slew bit not applied");
  a_bad_addr: assert property (psel && !penable && paddr[7] |=> pslverr)
    else $error("no error for unmapped address");
  a_tmpl_mirror: assert property (wr_go && wr_idx == GPG_SHARED_TEMPLATE
    |-> tmpl_wr && tmpl_wdata == pwdata[7:0])
    else $error("template mirror write missed");
  c_multi: cover property (wr_go && wr_idx == GPG_MULTI_UPDATE);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule : gpg_checker

bind gpg_top gpg_checker #(.PINS(PINS)) u_gpg_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
  .pad_in(pad_in), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
  .pad_buf_en(pad_buf_en), .slew_limit(slew_limit),
  .ovr_drive_en(ovr_drive_en), .event_out(event_out),
  .tmpl_wr(tmpl_wr), .tmpl_wdata(tmpl_wdata), .irq(irq));

// file: test/gpg_pads.sv
// gpg_pads: package pins with an outside source, pull-up and float.
// assumes all levels change just after the pclk rising edge.
`timescale 1ns/1ns
module gpg_pads #(
  parameter int PINS = 8
) (
  input wire logic pclk, // clock for the float pattern
  input wire logic [PINS-1:0] pad_out, // driven value
  input wire logic [PINS-1:0] pad_oe, // driver on
  input wire logic [PINS-1:0] pad_pull_up, // pull-up on
  input wire logic [PINS-1:0] ext_drive, // outside source active
  input wire logic [PINS-1:0] ext_level, // outside source level
  output logic [PINS-1:0] pad_in // resolved level
);
  logic [PINS-1:0] float_reg = '0;
  // an undriven pad wanders every cycle
  always @(posedge pclk) float_reg <= ~float_reg;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_drive[i]) pad_in[i] = ext_level[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_reg[i];
    end
  end
endmodule : gpg_pads

// file: test/gpg_pin_group_bench.sv
// gpg_pin_group_bench: random and corner tests of the pin group.
// assumes gpg_top, gpg_pads and the bound checker are compiled.
`timescale 1ns/1ns
module gpg_pin_group_bench;
  import gpg_pkg::*;
  localparam int PINS = 8;
  localparam gpg_idx_t GPG_PIN_CONTROL_1 = GPG_PIN_CONTROL_0 + 5'h01;
  localparam gpg_idx_t GPG_PIN_CONTROL_2 = GPG_PIN_CONTROL_0 + 5'h02;
  logic pclk = 0, presetn, psel, penable, pwrite, pready, pslverr, errq;
  logic [GPG_ADDR_W-1:0] paddr;
  logic [GPG_DATA_W-1:0] pwdata, prdata, rdq;
  logic [3:0] pstrb;
  logic slew_limit, tmpl_ext_wr, tmpl_wr, irq;
  logic [7:0] tmpl_ext_data, tmpl_wdata, d, e, old, drv, outv;
  logic [PINS-1:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_ttl_sel;
  logic [PINS-1:0] pad_buf_en, ovr_drive_en, ovr_drive_val, ovr_out_en;
  logic [PINS-1:0] ovr_out_val, event_out, ext_drive, ext_level;
  int fail_count = 0, checks_done = 0, op;
  gpg_idx_t ops [7] = '{GPG_DRIVE_SET, GPG_DRIVE_CLEAR, GPG_DRIVE_TOGGLE,
    GPG_OUTPUT_SET, GPG_OUTPUT_CLEAR, GPG_OUTPUT_TOGGLE, GPG_INPUT};
  always #50 pclk = ~pclk;
  gpg_top #(.PINS(PINS)) u_gpg_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pad_pull_up), .pad_ttl_sel(pad_ttl_sel),
    .pad_buf_en(pad_buf_en), .slew_limit(slew_limit),
    .ovr_drive_en(ovr_drive_en), .ovr_drive_val(ovr_drive_val),
    .ovr_out_en(ovr_out_en), .ovr_out_val(ovr_out_val),
    .tmpl_ext_wr(tmpl_ext_wr), .tmpl_ext_data(tmpl_ext_data),
    .tmpl_wr(tmpl_wr), .tmpl_wdata(tmpl_wdata), .event_out(event_out),
    .irq(irq));
  gpg_pads #(.PINS(PINS)) u_gpg_pads (.pclk(pclk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .ext_drive(ext_drive),
    .ext_level(ext_level), .pad_in(pad_in));
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v,
    input logic [3:0] s);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input gpg_idx_t i, input logic [7:0] v);
    apb(1'b1, {1'b0, i, 2'b00}, v, 4'h1);
    @(negedge pclk);
  endtask : wr
  task automatic rd(input gpg_idx_t i, input logic [7:0] x);
    apb(1'b0, {1'b0, i, 2'b00}, 8'h00, 4'h1);
    chk(rdq, {24'h0, x});
  endtask : rd
  function automatic logic [15:0] upd(int o, logic [7:0] v, logic [7:0] dv,
    logic [7:0] ov);
    case (o)
      0: dv = dv | v;
      1: dv = dv & ~v;
      2: dv = dv ^ v;
      3: ov = ov | v;
      4: ov = ov & ~v;
      default: ov = ov ^ v;
    endcase
    return {dv, ov};
  endfunction : upd
  initial begin
    {presetn, psel, penable, pwrite, tmpl_ext_wr} = '0;
    {paddr, pwdata, pstrb, tmpl_ext_data, ext_level} = '0;
    {ovr_drive_en, ovr_drive_val, ovr_out_en, ovr_out_val} = '0;
    ext_drive = '1;
    void'($urandom(32'ha6e64ab2));
    repeat (16) @(posedge pclk);
    chk(pad_oe, 0);
    chk(pad_buf_en, 8'hff);
    presetn <= 1'b1;
    for (int i = 0; i < PINS; i++) begin
      rd(gpg_idx_t'(GPG_PIN_CONTROL_0 + i), 8'h00);
    end
    rd(GPG_SHARED_TEMPLATE, GPG_BYTE_RST);
    {drv, outv} = '0;
    for (int k = 0; k < 40; k++) begin
      op = $urandom_range(6);
      d = 8'($urandom);
      wr(ops[op], d);
      {drv, outv} = upd(op, d, drv, outv);
      chk(pad_oe, drv);
      chk(pad_out, outv);
    end
    rd(GPG_DRIVE, drv);
    rd(GPG_ALIAS_DRIVE, drv);
    rd(GPG_ALIAS_OUTPUT, outv);
    wr(GPG_DRIVE, 8'h0f);
    drv = 8'h0f;
    @(posedge pclk);
    ext_level <= 8'($urandom);
    repeat (3) @(posedge pclk);
    e = (outv & drv) | (ext_level & ~drv);
    rd(GPG_INPUT, e);
    wr(GPG_PIN_CONTROL_0, 8'h80);
    chk(pad_out[0], {~outv[0]});
    // the flipped pad level needs two edges through the synchroniser
    repeat (2) @(posedge pclk);
    rd(GPG_ALIAS_INPUT, e);
    wr(GPG_OUTPUT_SET, 8'h01);
    chk(pad_out[0], 1'b0);
    outv[0] = 1'b1;
    wr(GPG_PIN_CONTROL_0, 8'h00);
    wr(GPG_DRIVE, 8'h00);
    wr(GPG_PIN_CONTROL_1, 8'h04);
    old = ext_level;
    @(posedge pclk);
    ext_level <= ~old;
    repeat (3) @(negedge pclk);
    chk(pad_buf_en, 8'hfd);
    chk(event_out, ~old & 8'hfd);
    e = (~old & 8'hfd) | (old & 8'h02);
    rd(GPG_INPUT, e);
    ext_drive <= 8'hfb;
    wr(GPG_PIN_CONTROL_2, 8'h48);
    chk(pad_pull_up, 8'h04);
    chk(pad_ttl_sel, 8'h04);
    repeat (3) @(posedge pclk);
    rd(GPG_INPUT, e | 8'h04);
    wr(GPG_DRIVE_SET, 8'h04);
    chk(pad_pull_up, 8'h00);
    ext_drive <= '1;
    ext_level <= '0;
    wr(GPG_SHARED_TEMPLATE, 8'h48);
    wr(GPG_MULTI_UPDATE, 8'h30);
    rd(GPG_PIN_CONTROL_7 - 3, 8'h48);
    wr(GPG_SHARED_TEMPLATE, 8'h81);
    wr(GPG_MULTI_SET, 8'h10);
    rd(GPG_PIN_CONTROL_7 - 3, 8'hc9);
    wr(GPG_SHARED_TEMPLATE, 8'h40);
    wr(GPG_MULTI_CLEAR, 8'h20);
    rd(GPG_PIN_CONTROL_7 - 2, 8'h08);
    rd(GPG_SHARED_TEMPLATE, 8'h40);
    @(posedge pclk);
    tmpl_ext_wr <= 1'b1;
    tmpl_ext_data <= 8'h22;
    @(posedge pclk);
    tmpl_ext_wr <= 1'b0;
    rd(GPG_SHARED_TEMPLATE, 8'h22);
    wr(GPG_GROUP_CONTROL, 8'h01);
    chk(slew_limit, 1'b1);
    wr(GPG_DRIVE, 8'h00);
    wr(GPG_PIN_CONTROL_7 - 3, 8'h00);
    wr(GPG_PIN_CONTROL_7 - 4, 8'h02);
    wr(GPG_INT_FLAGS, 8'hff);
    chk(irq, 1'b0);
    @(posedge pclk);
    ext_level <= 8'h08;
    repeat (4) @(negedge pclk);
    chk(irq, 1'b1);
    rd(GPG_ALIAS_FLAGS, 8'h08);
    wr(GPG_INT_FLAGS, 8'h08);
    chk(irq, 1'b0);
    wr(GPG_PIN_CONTROL_7 - 4, 8'h05);
    chk(irq, 1'b0);
    @(posedge pclk);
    ext_level <= 8'h00;
    repeat (4) @(negedge pclk);
    chk(irq, 1'b1);
    @(posedge pclk);
    {ovr_drive_en, ovr_drive_val, ovr_out_en, ovr_out_val} <= {4{8'h40}};
    @(negedge pclk);
    chk(pad_oe, 8'h40);
    chk(pad_out, outv | 8'h40);
    @(posedge pclk);
    {ovr_drive_en, ovr_drive_val, ovr_out_en, ovr_out_val} <= '0;
    apb(1'b0, 8'h80, 8'h00, 4'h1);
    chk(errq, 1'b1);
    chk(rdq, 0);
    apb(1'b0, 8'h3c, 8'h00, 4'h1);
    chk(errq, 1'b1);
    chk(rdq, 0);
    apb(1'b1, {1'b0, GPG_OUTPUT, 2'b00}, ~outv, 4'h0);
    rd(GPG_OUTPUT, outv);
    wr(GPG_DRIVE_SET, 8'h81);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(pad_oe, 8'h00);
    rd(GPG_DRIVE, 8'h00);
    summarize();
  end
endmodule : gpg_pin_group_bench
